// file: inc/rtrcr_params.svh
/*
  Constants of the command-addressed tuning and receive configuration registers:
  command codes, field positions, reset values and conversion figures.
  Assumes it is included by bare name, before the package that uses it.
*/
`ifndef RTRCR_PARAMS_SVH
`define RTRCR_PARAMS_SVH

// Command word framing
`define RTRCR_WORD_BITS        5'h10
`define RTRCR_WORD_OVER        5'h11
`define RTRCR_FREQ_CODE        4'hA
`define RTRCR_RXC_CODE         5'h12
`define RTRCR_BBF_CODE         8'hC2

// Reset values of the three command registers
`define RTRCR_FREQ_RESET       16'hA680
`define RTRCR_RXC_RESET        16'h9080
`define RTRCR_BBF_RESET        16'hC22C

// Channel value window and carrier arithmetic in 0.5 kHz units
`define RTRCR_CHANNEL_WORD_VALUE_MIN         12'h060
`define RTRCR_CHANNEL_WORD_VALUE_MAX         12'hF3F
`define RTRCR_HALFK_PER_B0     21'h0_4E20
`define RTRCR_HALFK_PER_STEP   21'h0_0005

// Receiver setup and status word field positions
`define RTRCR_PIN_FN_BIT       10
`define RTRCR_STRENGTH_BIT     7

// Baseband filter field positions and forced-one bits
`define RTRCR_BBF_AUTO_BIT     7
`define RTRCR_BBF_SPEED_BIT    6
`define RTRCR_BBF_FILTER_TYPE_SELECT_BIT     4
`define RTRCR_BBF_FIXED_MASK   8'h28

// Signal strength threshold ladder in dBm
`define RTRCR_THRESH_BASE      8'h99
`define RTRCR_THRESH_STEP      8'h06

// Least preamble lengths in bits for each clock-recovery speed
`define RTRCR_PREAMBLE_FAST    5'h06
`define RTRCR_PREAMBLE_SLOW    5'h0C

// Synchroniser idle value: select high, all else low
`define RTRCR_SYNC_RESET       4'h1

`endif

// file: inc/rtrcr_pkg.sv
/*
  Types and shared conversion functions of the configuration register block.
  Assumes rtrcr_params.svh is on the include path.
*/
`include "rtrcr_params.svh"

package rtrcr_pkg;

  // Command word receiver states
  typedef enum logic [0:0] {
    RX_IDLE  = 1'b0,
    RX_SHIFT = 1'b1
  } rtrcr_rx_state_t;

  // State of the principal module
  typedef struct packed {
    rtrcr_rx_state_t rxState;
    logic [15:0]     shiftWord;
    logic [4:0]      bitCount;
    logic            clkPrev;
    logic            wordTaken;
    logic [11:0]     channelWordValue;
    logic [20:0]     carrierHalfKhz;
    logic [10:0]     rxSetup;
    logic [7:0]      bbFilter;
    logic            crFastMode;
    logic [4:0]      preambleMinBits;
    logic            sharedPinOut;
    logic            extInterrupt;
  } rtrcr_cfg_state_t;

  // Synchroniser state
  typedef struct packed {
    logic [3:0] stage1;
    logic [3:0] stage2;
  } rtrcr_sync_state_t;

  // Comparator state
  typedef struct packed {
    logic signed [7:0] effThreshold;
    logic              above;
  } rtrcr_cmp_state_t;

  // Magnitude of LNA gain reduction in dB
  function automatic logic [7:0] rtrcr_lna_atten(input logic [1:0] code);
    unique case (code)
      2'h0: return 8'h00;
      2'h1: return 8'h0E;
      2'h2: return 8'h06;
      2'h3: return 8'h14;
    endcase
  endfunction : rtrcr_lna_atten

endpackage : rtrcr_pkg

// file: rtl/rtrcr_sync.sv
/*
  Two-flop synchroniser for the serial control pins and the shared pin input.
  Assumes a free-running core clock; the clock enable freezes it like all state.
*/
`timescale 1ns/10ps
`include "rtrcr_params.svh"

module rtrcr_sync (
  // Clock and control
  input  logic       core_clk,
  input  logic       reset,
  input  logic       ce,
  // Asynchronous inputs and their synchronised copies
  input  logic [3:0] asyncIn,
  output logic [3:0] syncOut
);
  import rtrcr_pkg::*;

  rtrcr_sync_state_t cur;
  rtrcr_sync_state_t next_cur;

  // Stage one feeds only stage two
  always_comb begin
    next_cur = cur;
    if (reset) begin
      next_cur.stage1 = `RTRCR_SYNC_RESET;
      next_cur.stage2 = `RTRCR_SYNC_RESET;
    end else if (ce) begin
      next_cur.stage1 = asyncIn;
      next_cur.stage2 = cur.stage1;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    cur <= next_cur;
  end

  assign syncOut = cur.stage2;

endmodule : rtrcr_sync

// file: rtl/rtrcr_rssi_cmp.sv
/*
  Digital signal strength comparator: effective threshold from the threshold
  code and the LNA gain reduction, and the comparison result for the status word.
  Assumes the strength sample comes from logic on the core clock.
*/
`timescale 1ns/10ps
`include "rtrcr_params.svh"

module rtrcr_rssi_cmp (
  // Clock and control
  input  logic              core_clk,
  input  logic              reset,
  input  logic              ce,
  // Configuration
  input  logic [2:0]        strengthThreshold,
  input  logic [1:0]        lnaLevel,
  // Measured strength in dBm
  input  logic signed [7:0] signalStrength,
  // Results
  output logic signed [7:0] effThreshold,
  output logic              strengthAbove
);
  import rtrcr_pkg::*;

  rtrcr_cmp_state_t  cur;
  rtrcr_cmp_state_t  next_cur;
  logic signed [7:0] rawThreshold;
  logic signed [7:0] effNow;

  // Threshold ladder plus gain reduction magnitude
  assign rawThreshold = $signed(`RTRCR_THRESH_BASE + 8'({5'h00, strengthThreshold}) * `RTRCR_THRESH_STEP);
  assign effNow       = rawThreshold + $signed(rtrcr_lna_atten(lnaLevel));

  // Compare sample against effective threshold
  always_comb begin
    next_cur = cur;
    if (reset) begin
      next_cur.effThreshold = 8'h00;
      next_cur.above        = 1'b0;
    end else if (ce) begin
      next_cur.effThreshold = effNow;
      next_cur.above        = signalStrength > effNow;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    cur <= next_cur;
  end

  assign effThreshold  = cur.effThreshold;
  assign strengthAbove = cur.above;

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  thresh_follows_gain_a: assert property (ce |=> effThreshold == $past(rawThreshold) + $signed(rtrcr_lna_atten($past(lnaLevel))))
    else $error("effective threshold wrong");
  above_flag_a: assert property (ce && signalStrength <= effNow |=> !strengthAbove)
    else $error("strength flag set at or below threshold");

endmodule : rtrcr_rssi_cmp

// file: rtl/rtrcr_config_regs.sv
/*
  Command-addressed channel, receiver and baseband filter configuration registers.
  A 16-bit command word arrives MSB first on the serial control pins; a complete
  word whose command code matches updates one register, unless it is a channel word outside the window. Assumes the serial clock
  is much slower than the core clock, and that the band select, lock status,
  valid-data and strength inputs come from logic on the core clock.
*/
`timescale 1ns/10ps
`include "rtrcr_params.svh"

module rtrcr_config_regs (
  // Clock and control
  input  logic              core_clk,
  input  logic              reset,
  input  logic              ce,
  // Serial control pins
  input  logic              spiSelN,
  input  logic              spiClk,
  input  logic              spiDataIn,
  // Shared interrupt / valid-data pin
  input  logic              sharedPinIn,
  output logic              sharedPinOut,
  output logic              sharedPinOe,
  // Internal sources on the core clock
  input  logic [1:0]        bandSelect,
  input  logic              validDataIndicator,
  input  logic              crLocked,
  input  logic signed [7:0] signalStrength,
  // Channel outputs
  output logic [11:0]       channelWordValue,
  output logic [20:0]       carrierHalfKhz,
  // Receiver setup outputs
  output logic              sharedPinFunction,
  output logic [1:0]        validResponseTime,
  output logic [2:0]        rxBandwidthCode,
  output logic [8:0]        rxBandwidthKhz,
  output logic [1:0]        lnaLevel,
  output logic [7:0]        lnaAttenDb,
  output logic [2:0]        strengthThreshold,
  output logic signed [7:0] effThreshold,
  output logic [15:0]       statusStrength,
  output logic              extInterrupt,
  // Baseband filter outputs
  output logic              autoLockSelect,
  output logic              manualLockSpeed,
  output logic              filterTypeSelect,
  output logic              digitalFilterEn,
  output logic              analogFilterEn,
  output logic [2:0]        qualityThreshold,
  output logic              crFastMode,
  output logic [4:0]        preambleMinBits,
  // Word acceptance pulse
  output logic              wordTaken
);
  import rtrcr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Functions

  // Carrier in 0.5 kHz units: B1 * (20000*B0 + 5*value)
  function automatic logic [20:0] carrier_half_khz(input logic [1:0] band, input logic [11:0] channel_word_value);
    logic [20:0] mult;
    logic [20:0] offs;
    logic [20:0] sum;
    mult = 21'h0_0001;
    offs = 21'h0_001F;
    unique case (band)
      2'h0: begin
        mult = 21'h0_0001;
        offs = 21'h0_001F;
      end
      2'h1: begin
        mult = 21'h0_0001;
        offs = 21'h0_002B;
      end
      2'h2: begin
        mult = 21'h0_0002;
        offs = 21'h0_002B;
      end
      2'h3: begin
        mult = 21'h0_0003;
        offs = 21'h0_001E;
      end
    endcase
    sum = 21'(offs * `RTRCR_HALFK_PER_B0) + 21'({9'h000, channel_word_value} * `RTRCR_HALFK_PER_STEP);
    return 21'(mult * sum);
  endfunction : carrier_half_khz

  // Baseband bandwidth in kHz, zero for reserved codes
  function automatic logic [8:0] bandwidth_khz(input logic [2:0] code);
    unique case (code)
      3'h1:    return 9'h190;
      3'h2:    return 9'h154;
      3'h3:    return 9'h10E;
      3'h4:    return 9'h0C8;
      3'h5:    return 9'h086;
      3'h6:    return 9'h043;
      default: return 9'h000;
    endcase
  endfunction : bandwidth_khz

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and strength comparison

  logic [3:0] pinSync;
  logic       selSync;
  logic       clkSync;
  logic       dataSync;
  logic       pinInSync;
  logic       strengthAbove;

  rtrcr_sync u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .ce       (ce),
    .asyncIn  ({sharedPinIn, spiDataIn, spiClk, spiSelN}),
    .syncOut  (pinSync)
  );

  assign {pinInSync, dataSync, clkSync, selSync} = pinSync;

  rtrcr_rssi_cmp u_cmp (
    .core_clk          (core_clk),
    .reset             (reset),
    .ce                (ce),
    .strengthThreshold (strengthThreshold),
    .lnaLevel          (lnaLevel),
    .signalStrength    (signalStrength),
    .effThreshold      (effThreshold),
    .strengthAbove     (strengthAbove)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode

  rtrcr_cfg_state_t cur;
  rtrcr_cfg_state_t next_cur;
  logic             clkRise;
  logic             frameDone;
  logic             commitFreq;
  logic             commitRx;
  logic             commitBbf;
  logic             fvalOk;
  logic             fastNext;

  // Serial clock edge and end of a full 16-bit frame
  assign clkRise    = clkSync && !cur.clkPrev;
  assign frameDone  = cur.rxState == RX_SHIFT && selSync && cur.bitCount == `RTRCR_WORD_BITS;
  // Command code matching on the shifted word
  assign commitFreq = frameDone && cur.shiftWord[15:12] == `RTRCR_FREQ_CODE;
  assign commitRx   = frameDone && cur.shiftWord[15:11] == `RTRCR_RXC_CODE;
  assign commitBbf  = frameDone && cur.shiftWord[15:8] == `RTRCR_BBF_CODE;
  // Channel window check
  assign fvalOk     = cur.shiftWord[11:0] >= `RTRCR_CHANNEL_WORD_VALUE_MIN && cur.shiftWord[11:0] <= `RTRCR_CHANNEL_WORD_VALUE_MAX;
  // Clock recovery speed: automatic follows lock, manual follows the speed bit
  assign fastNext   = cur.bbFilter[`RTRCR_BBF_AUTO_BIT] ? !crLocked : cur.bbFilter[`RTRCR_BBF_SPEED_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_cur = cur;
    if (reset) begin
      next_cur.rxState          = RX_IDLE;
      next_cur.shiftWord        = 16'h0000;
      next_cur.bitCount         = 5'h00;
      next_cur.clkPrev          = 1'b0;
      next_cur.wordTaken        = 1'b0;
      // Command registers keep only their field bits; the code bits are implied
      next_cur.channelWordValue = 12'(`RTRCR_FREQ_RESET);
      next_cur.carrierHalfKhz   = 21'h0_0000;
      next_cur.rxSetup          = 11'(`RTRCR_RXC_RESET);
      next_cur.bbFilter         = 8'(`RTRCR_BBF_RESET);
      next_cur.crFastMode       = 1'b0;
      next_cur.preambleMinBits  = `RTRCR_PREAMBLE_SLOW;
      next_cur.sharedPinOut     = 1'b0;
      next_cur.extInterrupt     = 1'b0;
    end else if (ce) begin
      next_cur.clkPrev   = clkSync;
      next_cur.wordTaken = commitFreq || commitRx || commitBbf;
      // Word receiver: shift MSB first on rising serial clock while selected
      unique case (cur.rxState)
        RX_IDLE: begin
          if (!selSync) begin
            next_cur.rxState  = RX_SHIFT;
            next_cur.bitCount = 5'h00;
          end
        end
        RX_SHIFT: begin
          if (selSync) begin
            next_cur.rxState = RX_IDLE;
          end else if (clkRise && cur.bitCount != `RTRCR_WORD_OVER) begin
            // Saturate one past a full word so a long frame never reads as 16
            next_cur.shiftWord = {cur.shiftWord[14:0], dataSync};
            next_cur.bitCount  = cur.bitCount + 5'h01;
          end
        end
      endcase
      // Channel register keeps its value on an out-of-window write
      if (commitFreq && fvalOk) begin
        next_cur.channelWordValue = cur.shiftWord[11:0];
      end
      // Receiver setup register
      if (commitRx) begin
        next_cur.rxSetup = cur.shiftWord[10:0];
      end
      // Filter register, unused bits held at one
      if (commitBbf) begin
        next_cur.bbFilter = cur.shiftWord[7:0] | `RTRCR_BBF_FIXED_MASK;
      end
      // Carrier from band and stored channel value
      next_cur.carrierHalfKhz  = carrier_half_khz(bandSelect, cur.channelWordValue);
      // Clock recovery mode and its least preamble
      next_cur.crFastMode      = fastNext;
      next_cur.preambleMinBits = fastNext ? `RTRCR_PREAMBLE_FAST : `RTRCR_PREAMBLE_SLOW;
      // Shared pin: valid-data out or interrupt in. Both follow the function bit
      // stored this cycle, so the pin never drives and listens at once
      next_cur.sharedPinOut    = next_cur.rxSetup[`RTRCR_PIN_FN_BIT] && validDataIndicator;
      next_cur.extInterrupt    = !next_cur.rxSetup[`RTRCR_PIN_FN_BIT] && pinInSync;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    cur <= next_cur;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Channel and carrier
  assign channelWordValue  = cur.channelWordValue;
  assign carrierHalfKhz    = cur.carrierHalfKhz;
  // Receiver setup fields
  assign sharedPinFunction = cur.rxSetup[`RTRCR_PIN_FN_BIT];
  assign validResponseTime = cur.rxSetup[9:8];
  assign rxBandwidthCode   = cur.rxSetup[7:5];
  assign rxBandwidthKhz    = bandwidth_khz(cur.rxSetup[7:5]);
  assign lnaLevel          = cur.rxSetup[4:3];
  assign lnaAttenDb        = rtrcr_lna_atten(cur.rxSetup[4:3]);
  assign strengthThreshold = cur.rxSetup[2:0];
  // Shared pin drive and interrupt
  assign sharedPinOut      = cur.sharedPinOut;
  assign sharedPinOe       = cur.rxSetup[`RTRCR_PIN_FN_BIT];
  assign extInterrupt      = cur.extInterrupt;
  // Strength flag in its status position
  assign statusStrength    = 16'(strengthAbove) << `RTRCR_STRENGTH_BIT;
  // Baseband filter fields
  assign autoLockSelect    = cur.bbFilter[`RTRCR_BBF_AUTO_BIT];
  assign manualLockSpeed   = cur.bbFilter[`RTRCR_BBF_SPEED_BIT];
  assign filterTypeSelect  = cur.bbFilter[`RTRCR_BBF_FILTER_TYPE_SELECT_BIT];
  assign digitalFilterEn   = cur.bbFilter[`RTRCR_BBF_FILTER_TYPE_SELECT_BIT];
  assign analogFilterEn    = !cur.bbFilter[`RTRCR_BBF_FILTER_TYPE_SELECT_BIT];
  assign qualityThreshold  = cur.bbFilter[2:0];
  assign crFastMode        = cur.crFastMode;
  assign preambleMinBits   = cur.preambleMinBits;
  assign wordTaken         = cur.wordTaken;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  chan_load_a: assert property (ce && commitFreq && fvalOk |=> channelWordValue == $past(cur.shiftWord[11:0]))
    else $error("valid channel write not stored");
  chan_keep_a: assert property (ce && commitFreq && !fvalOk |=> $stable(channelWordValue))
    else $error("out of window channel value stored");
  carrier_calc_a: assert property (ce && $stable(bandSelect) ##1 ce && $stable(channelWordValue)
                                   |=> carrierHalfKhz == carrier_half_khz($past(bandSelect),
                                                                          $past(channelWordValue)))
    else $error("carrier does not follow channel value");
  rx_fields_a: assert property (ce && commitRx |=> {sharedPinFunction, validResponseTime, rxBandwidthCode,
                                lnaLevel, strengthThreshold} == $past(cur.shiftWord[10:0]))
    else $error("receiver setup not stored");
  pin_dir_a: assert property (sharedPinOe == sharedPinFunction && !(sharedPinOe && extInterrupt))
    else $error("shared pin direction wrong");
  pin_out_a: assert property (!sharedPinFunction |-> !sharedPinOut)
    else $error("shared pin driven while an input");
  bbf_fields_a: assert property (ce && commitBbf |=> bbFilter_ok(cur.bbFilter, $past(cur.shiftWord[7:0])))
    else $error("filter word not stored");
  cr_auto_a: assert property (ce && autoLockSelect && crLocked |=> !crFastMode ##0 preambleMinBits == 5'h0C)
    else $error("automatic lock did not drop to slow");
  cr_manual_a: assert property (ce && !autoLockSelect && manualLockSpeed |=> crFastMode && preambleMinBits == 5'h06)
    else $error("manual fast mode wrong");
  filter_type_select_sel_a: assert property (digitalFilterEn == filterTypeSelect && analogFilterEn == !filterTypeSelect)
    else $error("filter path select wrong");
  no_commit_a: assert property (!frameDone |=> $stable(channelWordValue) && $stable(cur.rxSetup)
                                && $stable(cur.bbFilter))
    else $error("register changed without a full word");

  ////////////////////////////////////////////////////////////////////////////////
  // Frame and decode checks

  // Word acceptance pulse only follows a matched full word
  taken_pulse_a: assert property (ce && (commitFreq || commitRx || commitBbf) |=> wordTaken)
    else $error("matched word not flagged");
  taken_only_a: assert property (ce && !frameDone |=> !wordTaken)
    else $error("word flagged without a full frame");
  // Bit counter stays at or below one past a full word
  count_cap_a: assert property (cur.bitCount <= `RTRCR_WORD_OVER)
    else $error("bit counter overran");
  // Select rising ends the frame whenever the clock enable is high
  sel_end_a: assert property (ce && cur.rxState == RX_SHIFT && selSync |=> cur.rxState == RX_IDLE)
    else $error("frame not ended by select");
  // Stored channel value never leaves the legal window
  chan_window_a: assert property (channelWordValue >= `RTRCR_CHANNEL_WORD_VALUE_MIN &&
                                  channelWordValue <= `RTRCR_CHANNEL_WORD_VALUE_MAX)
    else $error("channel value outside window");
  // Only reserved bandwidth codes decode to zero
  bw_reserved_a: assert property ((rxBandwidthKhz == 9'h000) ==
                                  (rxBandwidthCode == 3'h0 || rxBandwidthCode == 3'h7))
    else $error("bandwidth decode wrong");
  // Strength flag is the only live status bit
  stat_bits_a: assert property ((statusStrength & 16'hFF7F) == 16'h0000)
    else $error("stray status bit set");
  // Automatic lock starts fast while unlocked; manual slow stays slow
  cr_start_a: assert property (ce && autoLockSelect && !crLocked |=> crFastMode)
    else $error("automatic lock did not start fast");
  cr_slow_a: assert property (ce && !autoLockSelect && !manualLockSpeed |=> !crFastMode)
    else $error("manual slow mode wrong");
  // Least preamble always matches the recovery speed
  pre_match_a: assert property (preambleMinBits ==
                                (crFastMode ? `RTRCR_PREAMBLE_FAST : `RTRCR_PREAMBLE_SLOW))
    else $error("preamble length wrong");

  // Stored filter byte equals the written byte with bits 5 and 3 forced high
  function automatic logic bbFilter_ok(input logic [7:0] stored, input logic [7:0] written);
    return stored == (written | `RTRCR_BBF_FIXED_MASK);
  endfunction : bbFilter_ok

endmodule : rtrcr_config_regs

// file: test/rtrcr_host_model.sv
/*
  Host model: sends command words on the serial control pins.
  Assumes the block samples data on the rising serial clock, MSB first.
*/
`timescale 1ns/10ps

module rtrcr_host_model (
  // Serial control pins
  output logic spiSelN,
  output logic spiClk,
  output logic spiDataIn
);
  // Idle: deselected, clock parked low
  initial begin
    spiSelN   = 1'b1;
    spiClk    = 1'b0;
    spiDataIn = 1'b0;
  end

  // Sends n bits of w, MSB first; 400 ns clock, data set while clock is low
  task automatic frame(input logic [16:0] w, input int n);
    spiSelN = 1'b0;
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      spiDataIn = w[i];
      #200 spiClk = 1'b1;
      #200 spiClk = 1'b0;
    end
    #200 spiSelN = 1'b1;
    // No pull on the data line, so show the inverse once released
    spiDataIn = ~spiDataIn;
  endtask : frame
endmodule : rtrcr_host_model

// file: test/tb.sv
/*
  Self-checking bench of the configuration registers.
  Assumes the host model drives the serial pins; core clock 20 MHz.
*/
`timescale 1ns/10ps

module tb;
  logic core_clk = 1'b0, reset = 1'b1, ce = 1'b1, sharedPinIn = 1'b0;
  logic validDataIndicator = 1'b0, crLocked = 1'b0, taken;
  logic [1:0] bandSelect = 2'h0;
  logic signed [7:0] signalStrength = 8'sh00;
  logic spiSelN, spiClk, spiDataIn, sharedPinOut, sharedPinOe, sharedPinFunction;
  logic extInterrupt, autoLockSelect, manualLockSpeed, filterTypeSelect;
  logic digitalFilterEn, analogFilterEn, crFastMode, wordTaken;
  logic [11:0] channelWordValue;
  logic [20:0] carrierHalfKhz;
  logic [1:0] validResponseTime, lnaLevel;
  logic [2:0] rxBandwidthCode, strengthThreshold, qualityThreshold;
  logic [8:0] rxBandwidthKhz;
  logic [7:0] lnaAttenDb;
  logic signed [7:0] effThreshold;
  logic [15:0] statusStrength;
  logic [4:0] preambleMinBits;
  int errorCnt = 0, nTests = 0;
  int mul[4] = '{1, 1, 2, 3};
  int off[4] = '{31, 43, 43, 30};
  logic [11:0] fv[4] = '{12'h060, 12'hF3F, 12'h7D0, 12'hF3F};
  logic [11:0] bad[4] = '{12'h05F, 12'hF40, 12'h000, 12'hFFF};
  int kbw[8] = '{0, 400, 340, 270, 200, 134, 67, 0};
  int att[4] = '{0, 14, 6, 20};
  logic [7:0] fb[4] = '{8'h03, 8'h52, 8'h90, 8'hC1};
  logic fe[4] = '{1'b0, 1'b1, 1'b1, 1'b1};

  ////////////////////////////////////////////////////////////////////////
  // Block under test and host
  rtrcr_config_regs rtrcr_config_regs_i (.core_clk, .reset, .ce, .spiSelN, .spiClk, .spiDataIn,
    .sharedPinIn, .sharedPinOut, .sharedPinOe, .bandSelect, .validDataIndicator, .crLocked,
    .signalStrength, .channelWordValue, .carrierHalfKhz, .sharedPinFunction, .validResponseTime,
    .rxBandwidthCode, .rxBandwidthKhz, .lnaLevel, .lnaAttenDb, .strengthThreshold, .effThreshold,
    .statusStrength, .extInterrupt, .autoLockSelect, .manualLockSpeed, .filterTypeSelect,
    .digitalFilterEn, .analogFilterEn, .qualityThreshold, .crFastMode, .preambleMinBits, .wordTaken);
  rtrcr_host_model rtrcr_host_model_i (.spiSelN, .spiClk, .spiDataIn);

  // Core clock, 50 ns period
  always #25 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////
  // Waits n edges, then 1 ns so inputs change off the edge
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step

  // Compares one result
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      errorCnt++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  // Sends one frame and notes whether a word was taken
  task automatic wr(input logic [16:0] w, input int n);
    taken = 1'b0;
    rtrcr_host_model_i.frame(w, n);
    for (int k = 0; k < 30; k++) begin
      step(1);
      if (wordTaken === 1'b1) taken = 1'b1;
    end
  endtask : wr

  // Prints the verdict and ends the run
  task automatic results();
    if (errorCnt == 0 && nTests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  // Watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    errorCnt++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    int car;
    logic [2:0] c, t;
    logic signed [7:0] ev;
    step(3);
    reset = 1'b0;
    step(2);
    chk("chan", 12'h0680, channelWordValue);
    chk("bw", 3'h4, rxBandwidthCode);
    chk("dq", 3'h4, qualityThreshold);
    chk("pre", 5'h0C, preambleMinBits);
    // Channel writes in every band, range ends included
    for (int b = 0; b < 4; b++) begin
      bandSelect = 2'(b);
      wr({5'h0A, fv[b]}, 16);
      car = mul[b] * (20000 * off[b] + 5 * fv[b]);
      chk("chan", fv[b], channelWordValue);
      chk("carrier", car, carrierHalfKhz);
      chk("taken", 1'b1, taken);
    end
    // Out-of-range values are dropped
    for (int i = 0; i < 4; i++) begin
      wr({5'h0A, bad[i]}, 16);
      chk("chan", fv[3], channelWordValue);
      chk("carrier", car, carrierHalfKhz);
    end
    // Clock enable low freezes the block through a whole frame
    ce = 1'b0;
    wr({5'h0A, 12'h100}, 16);
    ce = 1'b1;
    chk("taken", 1'b0, taken);
    chk("chan", fv[3], channelWordValue);
    // Short, long and unmatched frames
    wr({5'h0A, 12'h200} >> 1, 15);
    chk("taken", 1'b0, taken);
    wr({16'hA200, 1'b1}, 17);
    chk("taken", 1'b0, taken);
    wr({1'b0, 16'h9880}, 16);
    chk("taken", 1'b0, taken);
    chk("chan", fv[3], channelWordValue);
    chk("bw", 3'h4, rxBandwidthCode);
    // Receiver setup, all non-reserved bandwidths
    for (int i = 1; i < 7; i++) begin
      c = 3'(i);
      t = 3'(i * 3 + 5);
      ev = 8'(-103 + 6 * t + att[c[1:0]]);
      wr({1'b0, 5'h12, c[0], c[2:1], c, c[1:0], t}, 16);
      chk("pinfn", c[0], sharedPinFunction);
      chk("oe", c[0], sharedPinOe);
      chk("resp", c[2:1], validResponseTime);
      chk("bw", c, rxBandwidthCode);
      chk("khz", kbw[c], rxBandwidthKhz);
      chk("gain", c[1:0], lnaLevel);
      chk("atten", att[c[1:0]], lnaAttenDb);
      chk("thr", t, strengthThreshold);
      chk("eff", ev, effThreshold);
      signalStrength = ev + 8'sd1;
      step(3);
      chk("stat", 16'h0080, statusStrength);
      signalStrength = ev;
      step(3);
      chk("stat", 16'h0000, statusStrength);
      validDataIndicator = 1'b1;
      sharedPinIn = 1'b1;
      step(5);
      chk("pout", c[0], sharedPinOut);
      chk("irq", !c[0], extInterrupt);
      validDataIndicator = 1'b0;
      sharedPinIn = 1'b0;
      step(5);
      chk("pin", 2'h0, {sharedPinOut, extInterrupt});
    end
    // Filter words; bits 5 and 3 set, quality kept below 4
    for (int i = 0; i < 4; i++) begin
      wr({1'b0, 8'hC2, fb[i] | 8'h28}, 16);
      chk("auto", fb[i][7], autoLockSelect);
      chk("speed", fb[i][6], manualLockSpeed);
      chk("filter_type_select", fb[i][4], filterTypeSelect);
      chk("dig", fb[i][4], digitalFilterEn);
      chk("ana", !fb[i][4], analogFilterEn);
      chk("dq", fb[i][2:0], qualityThreshold);
      chk("fast", fe[i], crFastMode);
      chk("pre", fe[i] ? 5'h06 : 5'h0C, preambleMinBits);
    end
    // Automatic lock drops to slow once locked
    crLocked = 1'b1;
    step(4);
    chk("fast", 1'b0, crFastMode);
    chk("pre", 5'h0C, preambleMinBits);
    results();
  end
endmodule : tb
